// *** hw/hcpr_pkg.sv ***
/*
  constants for the host configuration and write-protection register bank.
  assumes a byte-wide register port on the core clock.
*/
package hcpr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] HCPR_SYNC_MON_OFS = 8'h7C;
  localparam logic [7:0] HCPR_IRQ_CFG_OFS = 8'h7D;
  localparam logic [7:0] HCPR_KEY_OFS = 8'h7E;
  localparam logic [7:0] HCPR_IFSEL_OFS = 8'h7F;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] HCPR_SYNC_MON_RST = 8'h2B;
  localparam logic [7:0] HCPR_IRQ_CFG_RST = 8'h02;
  localparam logic [7:0] HCPR_KEY_RST = 8'h85;
  localparam logic [2:0] HCPR_IFSEL_RST = 3'h0;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int HCPR_RECAL_BIT = 7;
  localparam int HCPR_LIMIT_LSB = 4;
  localparam int HCPR_POL_BIT = 0;
  localparam int HCPR_TRI_BIT = 1;
  localparam int HCPR_GPO_BIT = 2;
  // ----------------------------------------
  // key values and modes
  // ----------------------------------------
  localparam logic [7:0] HCPR_KEY_FULL = 8'h85;
  localparam logic [7:0] HCPR_KEY_SINGLE = 8'h86;
  localparam logic [7:0] HCPR_KEY_RELOCK = 8'h00;
  typedef enum logic [2:0] {
    HCPR_PROT = 3'b001,
    HCPR_FULL = 3'b010,
    HCPR_SINGLE = 3'b100
  } hcpr_prot_e;
  // interface select codes
  localparam logic [2:0] HCPR_IF_EPROM = 3'h1;
  localparam logic [2:0] HCPR_IF_MUX = 3'h2;
  localparam logic [2:0] HCPR_IF_INTEL = 3'h3;
  localparam logic [2:0] HCPR_IF_MOTO = 3'h4;
  localparam logic [2:0] HCPR_IF_SERIAL = 3'h5;
endpackage

// *** hw/hcpr_regs.sv ***
/*
  host configuration and write-protection register bank: frame sync source,
  interrupt pin configuration, protection key and host interface select.
  assumes a byte-wide register port driven by host interface logic on CORE_CLK;
  strap and sync pins arrive asynchronously.
*/
`timescale 1ns/10ps
module hcpr_regs (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RD_VALID,
  // straps and core status
  input wire logic [2:0] UPSEL_PINS,
  input wire logic IRQ_ACTIVE,
  input wire logic RECAL_DONE,
  // frame sync
  input wire logic EXT_SYNC_PIN,
  input wire logic SYNC_ENABLE,
  input wire logic DPLL_LOCKED,
  input wire logic [3:0] DPLL_SOURCE,
  output logic FRAME_SYNC_OUT,
  output logic [2:0] SYNC_MONITOR_LIMIT,
  output logic PHASE_OFFSET_RECAL_FORCE,
  // interrupt pin
  output logic IRQ_PIN_O,
  output logic IRQ_PIN_OE_N,
  // host interface and scan
  output logic [2:0] HOST_IF_MODE,
  output logic [4:0] PROT_STATE,
  output logic BSCAN_CORE_CAPTURE_EN,
  output logic TRST_PULL_DOWN_EN
);
  import hcpr_pkg::*;

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic rst_meta_q, rst_n;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // no reset here so straps are settled by the time reset releases
  logic [3:0] pin_meta_q, pin_sync_q;
  always_ff @(posedge CORE_CLK) begin
    pin_meta_q <= {EXT_SYNC_PIN, UPSEL_PINS};
    pin_sync_q <= pin_meta_q;
  end

  // ----------------------------------------
  // protection decode
  // ----------------------------------------
  function automatic hcpr_prot_e key_mode(input logic [7:0] key);
    if (key == HCPR_KEY_FULL) begin
      return HCPR_FULL;
    end else if (key == HCPR_KEY_SINGLE) begin
      return HCPR_SINGLE;
    end else begin
      return HCPR_PROT;
    end
  endfunction

  logic [7:0] key_q;
  logic [7:0] sync_mon_q;
  logic [2:0] irq_cfg_q;
  logic [2:0] ifsel_q;
  logic strap_done_q;
  hcpr_prot_e mode;
  logic key_wr, other_wr;

  always_comb begin
    mode = key_mode(key_q);
    key_wr = REG_WR && (REG_ADDR == HCPR_KEY_OFS);
    other_wr = REG_WR && (REG_ADDR != HCPR_KEY_OFS) && (mode != HCPR_PROT);
  end

  // ----------------------------------------
  // protection key
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= HCPR_KEY_RST;
    end else if (key_wr) begin
      key_q <= REG_WDATA;
    end else if (other_wr && mode == HCPR_SINGLE) begin
      key_q <= HCPR_KEY_RELOCK;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_mon_q <= HCPR_SYNC_MON_RST;
    end else if (other_wr && REG_ADDR == HCPR_SYNC_MON_OFS) begin
      sync_mon_q <= REG_WDATA;
    end else if (RECAL_DONE) begin
      // a write in the same cycle wins, so a fresh request is not lost
      sync_mon_q[HCPR_RECAL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_cfg_q <= HCPR_IRQ_CFG_RST[2:0];
    end else if (other_wr && REG_ADDR == HCPR_IRQ_CFG_OFS) begin
      irq_cfg_q <= REG_WDATA[2:0];
    end
  end

  // strap taken on the first edge after release, then only EPROM boot may write
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ifsel_q <= HCPR_IFSEL_RST;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      ifsel_q <= pin_sync_q[2:0];
      strap_done_q <= 1'b1;
    end else if (other_wr && REG_ADDR == HCPR_IFSEL_OFS && ifsel_q == HCPR_IF_EPROM) begin
      ifsel_q <= REG_WDATA[2:0];
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 8'h00;
      REG_RD_VALID <= 1'b0;
    end else begin
      REG_RD_VALID <= REG_RD;
      if (REG_RD) begin
        unique case (REG_ADDR)
          HCPR_SYNC_MON_OFS: REG_RDATA <= sync_mon_q;
          HCPR_IRQ_CFG_OFS: REG_RDATA <= {5'h00, irq_cfg_q};
          HCPR_KEY_OFS: REG_RDATA <= key_q;
          HCPR_IFSEL_OFS: REG_RDATA <= {5'h00, ifsel_q};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // frame sync gating
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      FRAME_SYNC_OUT <= 1'b0;
    end else begin
      FRAME_SYNC_OUT <= pin_sync_q[3] && SYNC_ENABLE && DPLL_LOCKED
                        && (DPLL_SOURCE == sync_mon_q[3:0]);
    end
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_PIN_O <= 1'b0;
      IRQ_PIN_OE_N <= 1'b1;
    end else if (irq_cfg_q[HCPR_GPO_BIT]) begin
      IRQ_PIN_O <= irq_cfg_q[HCPR_POL_BIT];
      IRQ_PIN_OE_N <= 1'b0;
    end else begin
      // an active interrupt drives the polarity bit, an idle one its inverse
      IRQ_PIN_O <= IRQ_ACTIVE ~^ irq_cfg_q[HCPR_POL_BIT];
      IRQ_PIN_OE_N <= irq_cfg_q[HCPR_TRI_BIT] && !IRQ_ACTIVE;
    end
  end

  // ----------------------------------------
  // mirrored outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SYNC_MONITOR_LIMIT <= HCPR_SYNC_MON_RST[6:4];
      PHASE_OFFSET_RECAL_FORCE <= HCPR_SYNC_MON_RST[7];
      HOST_IF_MODE <= HCPR_IFSEL_RST;
      PROT_STATE <= 5'h00;
    end else begin
      SYNC_MONITOR_LIMIT <= sync_mon_q[HCPR_LIMIT_LSB +: 3];
      PHASE_OFFSET_RECAL_FORCE <= sync_mon_q[HCPR_RECAL_BIT];
      HOST_IF_MODE <= ifsel_q;
      PROT_STATE <= {2'b00, mode};
    end
  end

  // scan: core capture stays off and test reset is pulled low in the pad
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BSCAN_CORE_CAPTURE_EN <= 1'b0;
      TRST_PULL_DOWN_EN <= 1'b1;
    end else begin
      BSCAN_CORE_CAPTURE_EN <= 1'b0;
      TRST_PULL_DOWN_EN <= 1'b1;
    end
  end
endmodule // hcpr_regs

// *** dv/hcpr_regs_assertions.sv ***
/*
  port checker for the host configuration register bank.
  assumes a bind onto hcpr_regs, one clock.
*/
`timescale 1ns/10ps
module hcpr_regs_assertions (
  // clock, reset, register port
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  // straps and outputs
  input wire logic [2:0] UPSEL_PINS,
  input wire logic IRQ_PIN_O,
  input wire logic IRQ_PIN_OE_N,
  input wire logic [2:0] HOST_IF_MODE,
  input wire logic [4:0] PROT_STATE,
  input wire logic BSCAN_CORE_CAPTURE_EN,
  input wire logic TRST_PULL_DOWN_EN
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  wire logic key_wr = REG_WR && REG_ADDR == 8'h7E;
  // no write a cycle earlier, so the mode output still matches the key
  a_capture_off: assert property (!BSCAN_CORE_CAPTURE_EN)
    else $error("core capture enabled");
  a_trst_pulled: assert property (TRST_PULL_DOWN_EN)
    else $error("test reset pull off");
  a_key_single: assert property (key_wr && REG_WDATA == 8'h86 |-> ##2 PROT_STATE == 5'h04)
    else $error("single mode missed");
  a_key_full: assert property (key_wr && REG_WDATA == 8'h85 |-> ##2 PROT_STATE == 5'h02)
    else $error("full mode missed");
  a_gpo_drive: assert property (REG_WR && REG_ADDR == 8'h7D && REG_WDATA[2]
    && PROT_STATE == 5'h02 && !$past(REG_WR) |-> ##2 !IRQ_PIN_OE_N
    && IRQ_PIN_O == $past(REG_WDATA[0], 2)) else $error("output pin wrong");
  a_single_relock: assert property (REG_WR && REG_ADDR != 8'h7E && PROT_STATE == 5'h04
    && !$past(REG_WR) |-> ##2 PROT_STATE == 5'h01) else $error("no relock");
  a_strap_load: assert property ($rose(NRST) |-> ##[3:5] HOST_IF_MODE == UPSEL_PINS)
    else $error("strap not loaded");
  a_ifsel_locked: assert property (REG_WR && REG_ADDR == 8'h7F && HOST_IF_MODE != 3'h1
    && !$past(REG_WR) |-> ##2 HOST_IF_MODE == $past(HOST_IF_MODE, 2))
    else $error("select changed");
  c_single: cover property (PROT_STATE == 5'h04);
  c_gpo: cover property (!IRQ_PIN_OE_N && IRQ_PIN_O);
  c_serial: cover property (HOST_IF_MODE == 3'h5);
endmodule // hcpr_regs_assertions
bind hcpr_regs hcpr_regs_assertions u_chk (.*);

// *** dv/hcpr_host_model.sv ***
/*
  host processor model driving the byte register port.
  assumes the bench calls cyc once per clock, starting at an edge.
*/
`timescale 1ns/10ps
module hcpr_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  initial begin
    {addr, wr, wdata, rd} = '0;
  end
  // one call per cycle keeps strobes up back to back, never set twice per step
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
endmodule // hcpr_host_model

// *** dv/hcpr_regs_tb_top.sv ***
/*
  self-checking bench for hcpr_regs.
  assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module hcpr_regs_tb_top;
  import hcpr_pkg::*;
  logic clk, nrst, wr, rd, rvalid, act, rdone, ext, sen, lock, fs, io, ioen;
  logic [7:0] addr, wdata, rdata, v;
  logic [3:0] src, s;
  logic [2:0] ups, ifm;
  logic [4:0] prot;
  logic [7:0] expq[$];
  logic [7:0] keys[6] = '{8'h00, 8'h84, 8'h86, 8'h87, 8'hFF, 8'h85};
  int num_errors = 0;
  int comparisons = 0;
  hcpr_host_model i_host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd));
  hcpr_regs i_dut (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RD_VALID(rvalid),
    .UPSEL_PINS(ups), .IRQ_ACTIVE(act), .RECAL_DONE(rdone), .EXT_SYNC_PIN(ext),
    .SYNC_ENABLE(sen), .DPLL_LOCKED(lock), .DPLL_SOURCE(src), .FRAME_SYNC_OUT(fs),
    .SYNC_MONITOR_LIMIT(), .PHASE_OFFSET_RECAL_FORCE(), .IRQ_PIN_O(io),
    .IRQ_PIN_OE_N(ioen), .HOST_IF_MODE(ifm), .PROT_STATE(prot),
    .BSCAN_CORE_CAPTURE_EN(), .TRST_PULL_DOWN_EN());
  // ----
  // tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    i_host.cyc(1'b1, 1'b0, a, d);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_host.cyc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) i_host.cyc(1'b0, 1'b0, addr, wdata);
  endtask
  task automatic do_reset(input logic [2:0] strap);
    nrst <= 1'b0;
    ups <= strap;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // read data is taken off the queue as each answer appears
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      chk(rdata, expq.size() > 0 ? expq.pop_front() : 8'hXX);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {nrst, ups, act, rdone, ext, sen, lock, src} = '0;
    void'($urandom(32'h76048524));
    do_reset(HCPR_IF_EPROM);
    rd8(HCPR_SYNC_MON_OFS, HCPR_SYNC_MON_RST);
    rd8(HCPR_IRQ_CFG_OFS, HCPR_IRQ_CFG_RST);
    rd8(HCPR_KEY_OFS, HCPR_KEY_RST);
    rd8(HCPR_IFSEL_OFS, 8'h01);
    rd8(8'h10, 8'h00);
    wr8(HCPR_IFSEL_OFS, 8'h05);
    idle(1);
    wr8(HCPR_IFSEL_OFS, 8'h01);
    rd8(HCPR_IFSEL_OFS, 8'h05);
    for (int c = 0; c < 16; c++) begin
      idle(1);
      wr8(HCPR_IRQ_CFG_OFS, {5'h00, c[2:0]});
      act <= c[3];
      idle(3);
      chk({6'h00, ioen, io}, {6'h00, (!c[2] && c[1] && !c[3]), (c[2] ? c[0] : c[3] ~^ c[0])});
    end
    foreach (keys[i]) begin
      wr8(HCPR_KEY_OFS, keys[i]);
      idle(2);
      chk({3'h0, prot}, {3'h0, (keys[i] == 8'h85 ? 5'h02 : keys[i] == 8'h86 ? 5'h04 : 5'h01)});
    end
    v = 8'($urandom);
    wr8(HCPR_KEY_OFS, 8'h00);
    wr8(HCPR_SYNC_MON_OFS, v);
    rd8(HCPR_SYNC_MON_OFS, HCPR_SYNC_MON_RST);
    wr8(HCPR_KEY_OFS, HCPR_KEY_SINGLE);
    idle(2);
    wr8(HCPR_SYNC_MON_OFS, v);
    wr8(HCPR_SYNC_MON_OFS, ~v);
    rd8(HCPR_SYNC_MON_OFS, v);
    rd8(HCPR_KEY_OFS, HCPR_KEY_RELOCK);
    s = 4'($urandom);
    wr8(HCPR_KEY_OFS, HCPR_KEY_FULL);
    wr8(HCPR_SYNC_MON_OFS, {4'h3, s});
    {ext, sen} <= 2'b11;
    for (int k = 0; k < 3; k++) begin
      src <= s + {3'h0, k == 1};
      lock <= k != 2;
      idle(5);
      chk({7'h00, fs}, {7'h00, k == 0});
    end
    do_reset(HCPR_IF_MOTO);
    rd8(HCPR_IFSEL_OFS, 8'h04);
    idle(1);
    wr8(HCPR_IFSEL_OFS, 8'h01);
    rd8(HCPR_IFSEL_OFS, 8'h04);
    idle(4);
    print_verdict();
  end
endmodule // hcpr_regs_tb_top
